// File: hdl/pssc_power_switch.sv
/*
  Front-panel power switch state control. Debounces the push button,
  times each press and moves the system between soft-off, working and
  sleeping. Assumes a free-running standby clock, a synchronous power-on
  reset, and an OS policy level and soft-off request from same-clock logic.

  Timing limitation: press length is counted on the debounced level, so
  both limits apply to the filtered press. Against the raw pin the force
  limit reads about two synchroniser cycles plus the debounce time late;
  the short limit does not shift, as both press edges are delayed alike.
  A press that is shorter than the debounce time is never seen at all.

  The fail-safe off acts while the switch is still held. It does not wait
  for the release, so a user who keeps holding sees the system go down.
*/
`timescale 1ns/100ps

module pssc_power_switch #(
  parameter int unsigned DEBOUNCE_CYC    = pssc_pkg::DEBOUNCE_CYC,
  parameter int unsigned SHORT_PRESS_CYC = pssc_pkg::SHORT_PRESS_CYC,
  parameter int unsigned FORCE_OFF_CYC   = pssc_pkg::FORCE_OFF_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  switch_pressed_n,
  input  wire logic                  os_policy_soft_off,
  input  wire logic                  os_soft_off_req,
  output pssc_pkg::pssc_state_t      sys_state,
  output pssc_pkg::pssc_status_t     sys_status,
  output logic                       press_active,
  output logic                       state_change
);

  localparam int CW = $clog2(FORCE_OFF_CYC + 2);
  localparam int DW = $clog2(DEBOUNCE_CYC + 2);

  // Elaboration-time checks on the timing parameters
  if (DEBOUNCE_CYC < 1)
  begin : g_bad_debounce
    $error("pssc_power_switch: debounce count must be at least one");
  end

  if (SHORT_PRESS_CYC < 1)
  begin : g_bad_short
    $error("pssc_power_switch: short press limit must be at least one");
  end

  // The force limit must lie beyond the short limit or a window never exists
  if (FORCE_OFF_CYC <= SHORT_PRESS_CYC)
  begin : g_bad_force
    $error("pssc_power_switch: force limit must exceed short press limit");
  end

  // A debounce slower than a short press would swallow every short press
  if (DEBOUNCE_CYC >= SHORT_PRESS_CYC)
  begin : g_bad_ratio
    $error("pssc_power_switch: debounce must be shorter than a short press");
  end

  logic                  sw_meta_ff;
  logic                  sw_sync_ff;
  logic [DW-1:0]         deb_cnt_ff;
  logic                  deb_ff;
  logic                  deb_prev_ff;
  logic [CW-1:0]         hold_cnt_ff;
  logic                  forced_ff;
  pssc_pkg::pssc_state_t state_ff;
  pssc_pkg::pssc_state_t nxt_state;
  logic                  chg_ff;
  logic                  release_evt;
  logic                  short_press;
  logic                  force_hit;

  // Two-stage synchroniser; the pin is active low
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sw_meta_ff <= 1'b0;
      sw_sync_ff <= 1'b0;
    end
    else
    begin
      sw_meta_ff <= ~switch_pressed_n;
      sw_sync_ff <= sw_meta_ff;
    end
  end

  // Level must hold steady for the debounce time before it is accepted
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      deb_cnt_ff <= '0;
      deb_ff     <= 1'b0;
    end
    else if (sw_sync_ff == deb_ff)
      deb_cnt_ff <= '0;
    else if (deb_cnt_ff == DW'(DEBOUNCE_CYC - 1))
    begin
      deb_cnt_ff <= '0;
      deb_ff     <= sw_sync_ff;
    end
    else
      deb_cnt_ff <= deb_cnt_ff + 1'b1;
  end

  // Delayed copy of the debounced level; reset matches the released pin
  // so no false release edge follows reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      deb_prev_ff <= 1'b0;
    else
      deb_prev_ff <= deb_ff;
  end

  // Hold counter saturates so very long presses cannot wrap into a short one
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      hold_cnt_ff <= '0;
    else if (!deb_ff)
      hold_cnt_ff <= '0;
    else if (hold_cnt_ff != CW'(FORCE_OFF_CYC + 1))
      hold_cnt_ff <= hold_cnt_ff + 1'b1;
  end

  // The hold count still holds the full press length in the release cycle,
  // since it clears only one cycle after the debounced level falls
  assign release_evt = deb_prev_ff && !deb_ff;
  assign short_press = release_evt && (hold_cnt_ff < CW'(SHORT_PRESS_CYC));
  assign force_hit   = deb_ff && (hold_cnt_ff == CW'(FORCE_OFF_CYC));

  // A forced off consumes the press: its release must not power on again
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      forced_ff <= 1'b0;
    else if (force_hit)
      forced_ff <= 1'b1;
    else if (!deb_ff)
      forced_ff <= 1'b0;
  end

  // OS request takes priority over switch events in the same cycle
  always_comb
  begin
    nxt_state = state_ff;
    if (os_soft_off_req)
      nxt_state = pssc_pkg::PSSC_SOFT_OFF;
    else if (force_hit && state_ff != pssc_pkg::PSSC_SOFT_OFF)
      nxt_state = pssc_pkg::PSSC_SOFT_OFF;
    else if (short_press && !forced_ff)
    begin
      case (state_ff)
        pssc_pkg::PSSC_SOFT_OFF:
          nxt_state = pssc_pkg::PSSC_WORKING;
        pssc_pkg::PSSC_WORKING:
        begin
          // Policy is sampled only in the release cycle
          if (os_policy_soft_off == pssc_pkg::POLICY_SOFT_OFF)
            nxt_state = pssc_pkg::PSSC_SOFT_OFF;
          else
            nxt_state = pssc_pkg::PSSC_SLEEPING;
        end
        pssc_pkg::PSSC_SLEEPING:
          nxt_state = pssc_pkg::PSSC_WORKING;
        default:
          nxt_state = pssc_pkg::PSSC_SOFT_OFF;
      endcase
    end
    // Releases between the two limits fall through unchanged
  end

  // The change pulse is registered with the state, so it stands in the
  // first cycle of the new state and never precedes it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_ff <= pssc_pkg::PSSC_SOFT_OFF;
      chg_ff   <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      chg_ff   <= (nxt_state != state_ff);
    end
  end

  // All outputs come straight from flip-flops or a decode of one register
  assign sys_state           = state_ff;
  assign sys_status.soft_off = (state_ff == pssc_pkg::PSSC_SOFT_OFF);
  assign sys_status.working  = (state_ff == pssc_pkg::PSSC_WORKING);
  assign sys_status.sleeping = (state_ff == pssc_pkg::PSSC_SLEEPING);
  assign press_active        = deb_ff;
  assign state_change        = chg_ff;

endmodule

// File: hdl/pssc_pkg.sv
/*
  Package for the power switch state control block: system states,
  debounce and hold-time constants derived from the standby clock.
  Assumes a 100 MHz standby clock.
*/
package pssc_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;

  // Debounce settle time in microseconds
  localparam int unsigned DEBOUNCE_US     = 10_000;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * (CLK_HZ / 1_000_000);

  // Short press limit and fail-safe hold limit, in seconds
  localparam int unsigned SHORT_PRESS_S   = 4;
  localparam int unsigned FORCE_OFF_S     = 6;
  localparam int unsigned SHORT_PRESS_CYC = SHORT_PRESS_S * CLK_HZ;
  localparam int unsigned FORCE_OFF_CYC   = FORCE_OFF_S * CLK_HZ;

  // Power policy encoding for a short press while working
  localparam logic        POLICY_SLEEP    = 1'b0;
  localparam logic        POLICY_SOFT_OFF = 1'b1;

  typedef enum logic [1:0] {
    PSSC_SOFT_OFF,
    PSSC_WORKING,
    PSSC_SLEEPING
  } pssc_state_t;

  typedef struct packed {
    logic soft_off;
    logic working;
    logic sleeping;
  } pssc_status_t;

endpackage

// File: testbench/pssc_power_switch_assertions.sv
/* Checker for pssc_power_switch state moves.
   Sees only the top ports; bound below the module. */
`timescale 1ns/100ps
module pssc_checker #(
  parameter int unsigned SHORT_PRESS_CYC = 40,
  parameter int unsigned FORCE_OFF_CYC   = 60
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              os_policy_soft_off,
  input wire logic              os_soft_off_req,
  input wire logic              press_active,
  input wire logic              state_change,
  input pssc_pkg::pssc_state_t  sys_state,
  input pssc_pkg::pssc_status_t sys_status
);
  logic [31:0] hold_ff;
  logic        rel;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk) hold_ff <= press_active ? hold_ff + 32'h1 : 32'h0;
  // High on the cycle just after a short press is let go
  assign rel = !press_active && hold_ff != 0 && hold_ff < SHORT_PRESS_CYC && !os_soft_off_req;
  property p_on; rel && sys_status.soft_off |=> sys_status.working; endproperty
  a_on: assert property (p_on) else $error("no power-on");
  property p_pol;
    rel && sys_status.working |=> (os_policy_soft_off ? sys_status.soft_off : sys_status.sleeping);
  endproperty
  a_pol: assert property (p_pol) else $error("bad policy move");
  property p_frc; hold_ff == FORCE_OFF_CYC && !sys_status.soft_off |-> ##[0:3] sys_status.soft_off;
  endproperty
  a_frc: assert property (p_frc) else $error("no forced off");
  property p_wk; rel && sys_status.sleeping |=> sys_status.working; endproperty
  a_wk: assert property (p_wk) else $error("no wake");
  property p_os; os_soft_off_req |=> sys_status.soft_off; endproperty
  a_os: assert property (p_os) else $error("os request ignored");
  property p_mid;
    !press_active && hold_ff >= SHORT_PRESS_CYC && !os_soft_off_req |=> $stable(sys_status);
  endproperty
  a_mid: assert property (p_mid) else $error("long release moved");
  // The change pulse stands exactly in the first cycle of a new state
  property p_chg; state_change == $changed(sys_status); endproperty
  a_chg: assert property (p_chg) else $error("change pulse wrong");
  property p_enc; sys_status.soft_off == (sys_state == pssc_pkg::PSSC_SOFT_OFF); endproperty
  a_enc: assert property (p_enc) else $error("state code disagrees");
  c_slp: cover property (sys_status.sleeping);
  c_wk: cover property (rel && sys_status.sleeping);
  c_os: cover property (os_soft_off_req && sys_status.working);
endmodule
bind pssc_power_switch pssc_checker #(
  .SHORT_PRESS_CYC(SHORT_PRESS_CYC),
  .FORCE_OFF_CYC  (FORCE_OFF_CYC)
) u_chk (
  .clk               (clk),
  .reset_n           (reset_n),
  .os_policy_soft_off(os_policy_soft_off),
  .os_soft_off_req   (os_soft_off_req),
  .press_active      (press_active),
  .state_change      (state_change),
  .sys_state         (sys_state),
  .sys_status        (sys_status)
);

// File: testbench/pssc_button_model.sv
/* Front-panel push button with a contact bounce.
   Idles high through its pull-up; pushed by task call. */
`timescale 1ns/100ps
module pssc_button_model (
  input wire logic clk,
  output logic     switch_pressed_n
);
  initial switch_pressed_n = 1'h1;
  task automatic push(input int n);
    // One-cycle bounce first, so debounce is exercised
    @(posedge clk) switch_pressed_n <= 1'h0;
    @(posedge clk) switch_pressed_n <= 1'h1;
    repeat (n) @(posedge clk) switch_pressed_n <= 1'h0;
    @(posedge clk) switch_pressed_n <= 1'h1;
  endtask
endmodule

// File: testbench/tb_top.sv
/* Bench for pssc_power_switch with shortened counts.
   Needs the button model and the bound checker. */
`timescale 1ns/100ps
module tb_top;
  logic                   clk = 1'h0;
  logic                   reset_n = 1'h0;
  logic                   switch_pressed_n;
  logic                   os_policy_soft_off = 1'h0;
  logic                   os_soft_off_req = 1'h0;
  pssc_pkg::pssc_status_t sys_status;
  pssc_pkg::pssc_state_t  sys_state;
  logic                   press_active;
  int                     n_mismatch = 0;
  int                     comparisons = 0;
  int                     cycles = 0;
  always #5 clk = ~clk;
  pssc_button_model u_btn (.clk(clk), .switch_pressed_n(switch_pressed_n));
  pssc_power_switch #(.DEBOUNCE_CYC(4), .SHORT_PRESS_CYC(40), .FORCE_OFF_CYC(60)) u_dut (
    .clk(clk), .reset_n(reset_n), .switch_pressed_n(switch_pressed_n),
    .os_policy_soft_off(os_policy_soft_off), .os_soft_off_req(os_soft_off_req),
    .sys_state(sys_state), .sys_status(sys_status), .press_active(press_active),
    .state_change());
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [2:0] exp);
    pssc_pkg::pssc_state_t exp_st;
    exp_st = (exp == 3'h4) ? pssc_pkg::PSSC_SOFT_OFF :
             (exp == 3'h2) ? pssc_pkg::PSSC_WORKING : pssc_pkg::PSSC_SLEEPING;
    comparisons++;
    if (sys_status !== exp)
    begin
      n_mismatch++;
      $display("ERROR sys_status expected %h seen %h", exp, sys_status);
    end
    comparisons++;
    if (sys_state !== exp_st)
    begin
      n_mismatch++;
      $display("ERROR sys_state expected %h seen %h", exp_st, sys_state);
    end
    comparisons++;
    if (press_active !== 1'h0)
    begin
      n_mismatch++;
      $display("ERROR press_active expected 0 seen %b", press_active);
    end
  endtask
  // Status is {soft_off, working, sleeping}
  task automatic press(input int n, input logic [2:0] exp);
    u_btn.push(n);
    repeat (12) @(posedge clk);
    chk(exp);
  endtask
  task automatic t_cycle;
    press(20, 3'h2);
    press(20, 3'h1);
    press(20, 3'h2);
    press(50, 3'h2);
  endtask
  task automatic t_force;
    press(80, 3'h4);
    press(20, 3'h2);
    press(20, 3'h1);
    press(80, 3'h4);
  endtask
  task automatic t_policy;
    os_policy_soft_off <= 1'h1;
    press(20, 3'h2);
    press(20, 3'h4);
  endtask
  task automatic t_os_req;
    press(20, 3'h2);
    os_soft_off_req <= 1'h1;
    @(posedge clk) os_soft_off_req <= 1'h0;
    @(posedge clk) chk(3'h4);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk);
    t_cycle();
    t_force();
    t_policy();
    t_os_req();
    end_of_test();
  end
endmodule
